// >>> core/rsfp_fifo.sv
`timescale 1ns/10ps
module rsfp_fifo import rsfp_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    // overflowing pushes and underflowing pops are dropped
    wire do_push = push && (count != (AW+1)'(DEPTH));
    wire do_pop = pop && (count != '0);
    assign rdata = mem[rptr];
    always_ff @(posedge clk) begin
        if (do_push) mem[wptr] <= wdata;
    end
    always_ff @(posedge clk) begin
        if (!nrst || clear) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            wptr <= wptr + AW'(do_push);
            rptr <= rptr + AW'(do_pop);
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : rsfp_fifo

// >>> core/rsfp_pkg.sv
// Functional notes
// (R1) hop step register counts unsigned 10 kHz units per channel number.
// (R2) carrier offset equals channel number times step size times 10 kHz.
// (R3) tx almost-full threshold in low six bits, resets to 0x37.
// (R4) tx almost-empty threshold in low six bits of second register.
// (R5) rx almost-full threshold in low six bits, resets to 0x37.
// (R6) fifo flags come from fill count compared with thresholds.
// (R7) write to fifo port address bursts every following byte into tx fifo.
// (R8) fifo port bursts keep the address fixed; other bursts increment.
// (R9) host ends a tx fifo burst by raising select.
// (R10) read of fifo port address bursts bytes popped from rx fifo.
// (R11) serial input is sampled on rising serial clock edges.
// (R12) low select enables the bus and spans multi-byte bursts.
// (R13) first byte is read/write flag then seven-bit address.
// (R14) read transactions shift register contents out on serial output.
// (R15) interrupt output goes low while any enabled event is pending.
// (R16) pending events are readable in status registers 0x03 and 0x04.
// (R17) power-down input high clears all register contents.
// (R18) host holds power-down low outside shutdown.
// (R19) host drives transmit antenna select high while transmitting.
// (R20) host drives receive antenna select high while receiving.
// (R21) three general-purpose pins route functions per their config registers.
package rsfp_pkg;
    localparam logic [6:0] ADDR_IRQ_STAT1 = 7'h03;
    localparam logic [6:0] ADDR_IRQ_STAT2 = 7'h04;
    localparam logic [6:0] ADDR_IRQ_EN1 = 7'h05;
    localparam logic [6:0] ADDR_IRQ_EN2 = 7'h06;
    localparam logic [6:0] ADDR_GPIO0_CFG = 7'h0B;
    localparam logic [6:0] ADDR_GPIO1_CFG = 7'h0C;
    localparam logic [6:0] ADDR_GPIO2_CFG = 7'h0D;
    localparam logic [6:0] ADDR_HOP_CHANNEL = 7'h79;
    localparam logic [6:0] ADDR_HOP_STEP = 7'h7A;
    localparam logic [6:0] ADDR_TX_FULL_LEVEL = 7'h7C;
    localparam logic [6:0] ADDR_TX_EMPTY_LEVEL = 7'h7D;
    localparam logic [6:0] ADDR_RX_FULL_LEVEL = 7'h7E;
    localparam logic [6:0] ADDR_FIFO_PORT = 7'h7F;
    localparam logic [7:0] RST_HOP_STEP = 8'h00;
    localparam logic [7:0] RST_HOP_CHANNEL = 8'h00;
    localparam logic [7:0] RST_TX_FULL_LEVEL = 8'h37;
    localparam logic [7:0] RST_TX_EMPTY_LEVEL = 8'h04;
    localparam logic [7:0] RST_RX_FULL_LEVEL = 8'h37;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_GPIO_CFG = 8'h00;
    localparam int HOP_UNIT_KHZ = 10;
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_W = 6;
    localparam int FIFO_DEPTH = 64;
    // status bit positions in the first status register
    localparam int STAT_TX_FULL = 6;
    localparam int STAT_TX_EMPTY = 5;
    localparam int STAT_RX_FULL = 4;
    // gpio function selects
    localparam logic [2:0] GPIO_FN_LOW = 3'h0;
    localparam logic [2:0] GPIO_FN_TX_FULL = 3'h1;
    localparam logic [2:0] GPIO_FN_TX_EMPTY = 3'h2;
    localparam logic [2:0] GPIO_FN_RX_FULL = 3'h3;
    localparam logic [2:0] GPIO_FN_TRANSMIT_ANTENNA_SELECT = 3'h4;
    localparam logic [2:0] GPIO_FN_RECEIVE_ANTENNA_SELECT = 3'h5;
    localparam logic [2:0] GPIO_FN_IRQ = 3'h6;
    localparam logic [2:0] GPIO_FN_HIGH = 3'h7;
    typedef enum logic [1:0] {
        RSFP_IDLE = 2'b00,
        RSFP_ADDR = 2'b01,
        RSFP_DATA = 2'b10
    } rsfp_state_e;
endpackage : rsfp_pkg

// >>> core/rsfp_port.sv
`timescale 1ns/10ps
module rsfp_port import rsfp_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic interrupt_out_n,
    input wire logic power_down_in,
    input wire logic transmit_antenna_select,
    input wire logic receive_antenna_select,
    input wire logic [2:0] gpio_in,
    output logic [2:0] gpio_out,
    output logic [2:0] gpio_oe,
    output logic tx_pop,
    output logic [7:0] tx_data,
    output logic tx_data_valid,
    input wire logic rx_push,
    input wire logic [7:0] rx_data,
    input wire logic [7:0] radio_events,
    output logic [15:0] hop_offset_10khz
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sck_prev;
    always_ff @(posedge clk) begin
        sync1 <= {serial_clk, serial_select_n, serial_in, power_down_in};
        sync2 <= sync1;
    end
    logic [1:0] ant_s1;
    logic [1:0] ant_s2;
    logic [2:0] gpi_s1;
    logic [2:0] gpi_s2;
    always_ff @(posedge clk) begin
        ant_s1 <= {transmit_antenna_select, receive_antenna_select};
        ant_s2 <= ant_s1;
        gpi_s1 <= gpio_in;
        gpi_s2 <= gpi_s1;
    end
    wire sck_s = sync2[3];
    wire sel_n_s = sync2[2];
    wire sdi_s = sync2[1];
    wire pdn_s = sync2[0];
    // power-down acts as a full reset of every register except the pin synchronisers and the fifo storage
    wire rst_all = !nrst || pdn_s; // [R17]
    always_ff @(posedge clk) begin
        if (rst_all) sck_prev <= 1'b0;
        else sck_prev <= sck_s;
    end
    wire sck_rise = sck_s && !sck_prev && !sel_n_s; // [R11] [R12]
    wire sck_fall = !sck_s && sck_prev && !sel_n_s;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] hop_step_size;
    logic [7:0] hop_channel;
    logic [7:0] tx_fifo_full_level;
    logic [7:0] tx_fifo_empty_level;
    logic [7:0] rx_fifo_full_level;
    logic [7:0] irq_enable1;
    logic [7:0] irq_enable2;
    logic [7:0] gpio_cfg [3];
    logic [7:0] irq_status1;
    logic [7:0] irq_status2;

    // ----------------------------------------------------------------
    // serial engine
    // ----------------------------------------------------------------
    rsfp_state_e state;
    rsfp_state_e next_state;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [6:0] addr;
    logic is_write;
    logic [7:0] shift_out;
    wire [7:0] next_shift_in = {shift_in[6:0], sdi_s};
    wire byte_done = sck_rise && (bit_cnt == 3'h7);
    wire at_port = (addr == ADDR_FIFO_PORT);
    // first byte: flag then seven-bit address
    wire hdr_done = byte_done && (state == RSFP_ADDR); // [R13]
    wire data_done = byte_done && (state == RSFP_DATA);
    wire wr_strobe = data_done && is_write;
    wire [6:0] next_addr = at_port ? addr : addr + 7'h01; // [R8]
    logic [7:0] rd_value;
    wire load_read = (hdr_done && !next_shift_in[7]) || (data_done && !is_write);
    wire [6:0] rd_addr = hdr_done ? next_shift_in[6:0] : next_addr;
    wire rd_port = load_read && (rd_addr == ADDR_FIFO_PORT); // [R10]

    always_comb begin
        next_state = state;
        case (state)
            RSFP_IDLE: next_state = RSFP_ADDR;
            RSFP_ADDR: if (hdr_done) next_state = RSFP_DATA;
            RSFP_DATA: next_state = RSFP_DATA;
            default: next_state = RSFP_IDLE;
        endcase
        if (sel_n_s) next_state = RSFP_IDLE; // [R9] [R12]
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            state <= RSFP_IDLE;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            addr <= 7'h00;
            is_write <= 1'b0;
        end else begin
            state <= next_state;
            if (sel_n_s) bit_cnt <= 3'h0;
            else if (sck_rise) bit_cnt <= bit_cnt + 3'h1;
            if (sck_rise) shift_in <= next_shift_in; // [R11]
            if (hdr_done) begin
                is_write <= next_shift_in[7];
                addr <= next_shift_in[6:0];
            end else if (data_done) begin
                addr <= next_addr; // [R8]
            end
        end
    end

    // ----------------------------------------------------------------
    // fifos
    // ----------------------------------------------------------------
    logic [6:0] tx_count;
    logic [6:0] rx_count;
    logic [7:0] rx_head;
    wire tx_push = wr_strobe && at_port; // [R7]
    wire rx_pop = rd_port; // [R10]
    rsfp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(clk), .nrst(!rst_all), .clear(1'b0),
        .push(tx_push), .wdata(next_shift_in),
        .pop(tx_pop), .rdata(tx_data), .count(tx_count)
    );
    rsfp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk), .nrst(!rst_all), .clear(1'b0),
        .push(rx_push), .wdata(rx_data),
        .pop(rx_pop), .rdata(rx_head), .count(rx_count)
    );
    assign tx_data_valid = (tx_count != 7'h00);

    // level compare against the programmed six-bit thresholds
    wire [6:0] tx_full_thr = {1'b0, tx_fifo_full_level[LEVEL_LSB +: LEVEL_W]};
    wire [6:0] tx_empty_thr = {1'b0, tx_fifo_empty_level[LEVEL_LSB +: LEVEL_W]};
    wire [6:0] rx_full_thr = {1'b0, rx_fifo_full_level[LEVEL_LSB +: LEVEL_W]};
    wire tx_almost_full = (tx_count >= tx_full_thr); // [R6] [R3]
    wire tx_almost_empty = (tx_count <= tx_empty_thr); // [R6] [R4]
    wire rx_almost_full = (rx_count >= rx_full_thr); // [R6] [R5]
    logic tx_full_q;
    logic tx_empty_q;
    logic rx_full_q;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    wire wr_hop_step = wr_strobe && (addr == ADDR_HOP_STEP);
    wire wr_hop_chan = wr_strobe && (addr == ADDR_HOP_CHANNEL);
    wire wr_tx_full = wr_strobe && (addr == ADDR_TX_FULL_LEVEL);
    wire wr_tx_empty = wr_strobe && (addr == ADDR_TX_EMPTY_LEVEL);
    wire wr_rx_full = wr_strobe && (addr == ADDR_RX_FULL_LEVEL);
    wire wr_en1 = wr_strobe && (addr == ADDR_IRQ_EN1);
    wire wr_en2 = wr_strobe && (addr == ADDR_IRQ_EN2);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            hop_step_size <= RST_HOP_STEP;
            hop_channel <= RST_HOP_CHANNEL;
            tx_fifo_full_level <= RST_TX_FULL_LEVEL; // [R3]
            tx_fifo_empty_level <= RST_TX_EMPTY_LEVEL;
            rx_fifo_full_level <= RST_RX_FULL_LEVEL; // [R5]
            irq_enable1 <= RST_IRQ_EN;
            irq_enable2 <= RST_IRQ_EN;
        end else begin
            if (wr_hop_step) hop_step_size <= next_shift_in; // [R1]
            if (wr_hop_chan) hop_channel <= next_shift_in;
            if (wr_tx_full) tx_fifo_full_level <= next_shift_in;
            if (wr_tx_empty) tx_fifo_empty_level <= {2'b00, next_shift_in[5:0]}; // [R4]
            if (wr_rx_full) rx_fifo_full_level <= next_shift_in;
            if (wr_en1) irq_enable1 <= next_shift_in;
            if (wr_en2) irq_enable2 <= next_shift_in;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_gpio
            wire wr_cfg = wr_strobe && (addr == ADDR_GPIO0_CFG + 7'(gi));
            always_ff @(posedge clk) begin
                if (rst_all) gpio_cfg[gi] <= RST_GPIO_CFG;
                else if (wr_cfg) gpio_cfg[gi] <= next_shift_in;
            end
            logic fn_val;
            always_comb begin
                case (gpio_cfg[gi][2:0])
                    GPIO_FN_LOW: fn_val = 1'b0;
                    GPIO_FN_TX_FULL: fn_val = tx_full_q;
                    GPIO_FN_TX_EMPTY: fn_val = tx_empty_q;
                    GPIO_FN_RX_FULL: fn_val = rx_full_q;
                    GPIO_FN_TRANSMIT_ANTENNA_SELECT: fn_val = ant_s2[1];
                    GPIO_FN_RECEIVE_ANTENNA_SELECT: fn_val = ant_s2[0];
                    GPIO_FN_IRQ: fn_val = !interrupt_out_n;
                    default: fn_val = 1'b1;
                endcase
            end
            // cfg bit 3 set turns the pin into an input
            always_ff @(posedge clk) begin
                if (rst_all) begin
                    gpio_out[gi] <= 1'b0;
                    gpio_oe[gi] <= 1'b0;
                end else begin
                    gpio_out[gi] <= fn_val; // [R21]
                    gpio_oe[gi] <= !gpio_cfg[gi][3];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt status: sticky, cleared by reading, set wins
    // ----------------------------------------------------------------
    wire tx_full_rise = tx_almost_full && !tx_full_q;
    wire tx_empty_rise = tx_almost_empty && !tx_empty_q;
    wire rx_full_rise = rx_almost_full && !rx_full_q;
    wire [7:0] ev1 = radio_events | ({7'h00, tx_full_rise} << STAT_TX_FULL) |
                     ({7'h00, tx_empty_rise} << STAT_TX_EMPTY) | ({7'h00, rx_full_rise} << STAT_RX_FULL);
    wire clr1 = load_read && (rd_addr == ADDR_IRQ_STAT1);
    wire clr2 = load_read && (rd_addr == ADDR_IRQ_STAT2);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            tx_full_q <= 1'b0;
            tx_empty_q <= 1'b0;
            rx_full_q <= 1'b0;
            irq_status1 <= 8'h00;
            irq_status2 <= 8'h00;
            interrupt_out_n <= 1'b1;
        end else begin
            tx_full_q <= tx_almost_full;
            tx_empty_q <= tx_almost_empty;
            rx_full_q <= rx_almost_full;
            irq_status1 <= (clr1 ? 8'h00 : irq_status1) | ev1; // [R16]
            irq_status2 <= (clr2 ? 8'h00 : irq_status2) | {5'h00, gpi_s2};
            interrupt_out_n <= !(|(irq_status1 & irq_enable1) || |(irq_status2 & irq_enable2)); // [R15]
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        case (rd_addr)
            ADDR_IRQ_STAT1: rd_value = irq_status1; // [R16]
            ADDR_IRQ_STAT2: rd_value = irq_status2;
            ADDR_IRQ_EN1: rd_value = irq_enable1;
            ADDR_IRQ_EN2: rd_value = irq_enable2;
            ADDR_GPIO0_CFG: rd_value = gpio_cfg[0];
            ADDR_GPIO1_CFG: rd_value = gpio_cfg[1];
            ADDR_GPIO2_CFG: rd_value = gpio_cfg[2];
            ADDR_HOP_CHANNEL: rd_value = hop_channel;
            ADDR_HOP_STEP: rd_value = hop_step_size;
            ADDR_TX_FULL_LEVEL: rd_value = tx_fifo_full_level;
            ADDR_TX_EMPTY_LEVEL: rd_value = tx_fifo_empty_level;
            ADDR_RX_FULL_LEVEL: rd_value = rx_fifo_full_level;
            ADDR_FIFO_PORT: rd_value = (rx_count != 7'h00) ? rx_head : 8'h00; // [R10]
            default: rd_value = 8'h00;
        endcase
    end
    // output changes on falling edges so the host samples it on rising ones
    always_ff @(posedge clk) begin
        if (rst_all) begin
            shift_out <= 8'h00;
            serial_out <= 1'b0;
        end else begin
            if (load_read) shift_out <= rd_value; // [R14]
            else if (sck_fall && state == RSFP_DATA) shift_out <= {shift_out[6:0], 1'b0};
            if (sck_fall) serial_out <= (state == RSFP_DATA && !is_write) ? shift_out[7] : 1'b0; // [R14]
        end
    end

    // the tx drain takes one byte per cycle while transmit antenna select is high and receive antenna select is low
    assign tx_pop = tx_data_valid && ant_s2[1] && !ant_s2[0];

    // ----------------------------------------------------------------
    // hop offset
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst_all) hop_offset_10khz <= 16'h0000;
        else hop_offset_10khz <= 16'(hop_channel) * 16'(hop_step_size); // [R1] [R2]
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_HOP: assert property (@(posedge clk) disable iff (rst_all) // [R2]
        (wr_hop_step || wr_hop_chan) |-> ##2 hop_offset_10khz == 16'(hop_channel) * 16'(hop_step_size))
        else $error("hop offset wrong");
    AST_TXPUSH: assert property (@(posedge clk) disable iff (rst_all) // [R7]
        (wr_strobe && at_port && tx_count < 7'h40 && !tx_pop) |=> tx_count == $past(tx_count) + 7'h01)
        else $error("tx byte not pushed");
    AST_ADDRFIX: assert property (@(posedge clk) disable iff (rst_all) // [R8]
        (data_done && at_port) |=> addr == ADDR_FIFO_PORT)
        else $error("fifo address moved");
    AST_ADDRINC: assert property (@(posedge clk) disable iff (rst_all) // [R8]
        (data_done && !at_port) |=> addr == $past(addr) + 7'h01)
        else $error("address not incremented");
    AST_RXPOP: assert property (@(posedge clk) disable iff (rst_all) // [R10]
        (rd_port && rx_count != 7'h00 && !rx_push) |=> rx_count == $past(rx_count) - 7'h01)
        else $error("rx byte not popped");
    AST_IDLE: assert property (@(posedge clk) disable iff (rst_all) // [R12]
        sel_n_s |=> state == RSFP_IDLE && bit_cnt == 3'h0)
        else $error("engine active while deselected");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst_all) // [R15]
        (|(irq_status1 & irq_enable1)) |=> !interrupt_out_n)
        else $error("interrupt not raised");
    AST_TXLVL: assert property (@(posedge clk) disable iff (rst_all) // [R6]
        tx_count >= {1'b0, tx_fifo_full_level[5:0]} |=> tx_full_q)
        else $error("almost full missed");
    AST_STICKY: assert property (@(posedge clk) disable iff (rst_all) // [R16]
        (ev1[STAT_TX_FULL]) |=> irq_status1[STAT_TX_FULL])
        else $error("event lost");
    AST_RES: assert property (@(posedge clk) // [R17]
        pdn_s |=> tx_fifo_full_level == RST_TX_FULL_LEVEL && hop_step_size == RST_HOP_STEP)
        else $error("power down kept registers");
    AST_TXEMPTY: assert property (@(posedge clk) disable iff (rst_all) // [R4] [R6]
        tx_count <= {1'b0, tx_fifo_empty_level[5:0]} |=> tx_empty_q)
        else $error("almost empty missed");
    AST_RXLVL: assert property (@(posedge clk) disable iff (rst_all) // [R5] [R6]
        rx_count >= {1'b0, rx_fifo_full_level[5:0]} |=> rx_full_q)
        else $error("rx almost full missed");
    AST_TXPOP: assert property (@(posedge clk) disable iff (rst_all) // [R7]
        (tx_pop && !tx_push) |=> tx_count == $past(tx_count) - 7'h01)
        else $error("tx byte not drained");
    AST_WRHOP: assert property (@(posedge clk) disable iff (rst_all) // [R1]
        wr_hop_step |=> hop_step_size == $past(next_shift_in))
        else $error("hop step not written");
    AST_RXLOAD: assert property (@(posedge clk) disable iff (rst_all) // [R10]
        (rd_port && rx_count != 7'h00) |=> shift_out == $past(rx_head))
        else $error("rx head not loaded");
    AST_SOUT: assert property (@(posedge clk) disable iff (rst_all) // [R14]
        (sck_fall && state == RSFP_DATA && !is_write) |=> serial_out == $past(shift_out[7]))
        else $error("read bit not shifted out");
    AST_GPIO: assert property (@(posedge clk) disable iff (rst_all) // [R21]
        (gpio_cfg[0][2:0] == GPIO_FN_HIGH && !gpio_cfg[0][3]) |=> gpio_out[0] && gpio_oe[0])
        else $error("gpio function not routed");
endmodule : rsfp_port

// >>> sim/rsfp_host.sv
`timescale 1ns/10ps
// ----------------------------------------
// host serial master
// ----------------------------------------
// serial clock idles low and only toggles inside frames
module rsfp_host (
    input wire logic clk,
    input wire logic serial_out,
    output logic serial_clk,
    output logic serial_select_n,
    output logic serial_in
);
    initial begin
        serial_clk = 1'b0;
        serial_select_n = 1'b1;
        serial_in = 1'b0;
    end

    // six clk cycles per phase gives the 48 ns serial period
    task automatic half;
        repeat (6) @(posedge clk);
        #1;
    endtask : half

    // msb first; device samples on the rising edge, read data is taken there too
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            serial_in = tx[i];
            half();
            serial_clk = 1'b1;
            rx[i] = serial_out;
            half();
            serial_clk = 1'b0;
        end
    endtask : shift

    // header byte is the write flag then the seven-bit address
    task automatic start(input logic wr, input logic [6:0] addr);
        logic [7:0] d;
        serial_select_n = 1'b0;
        half();
        shift({wr, addr}, d);
    endtask : start

    // released data line shows the inverse so a stale bit cannot pass
    task automatic stop;
        logic last;
        last = serial_in;
        half();
        serial_select_n = 1'b1;
        serial_in = ~last;
        half();
    endtask : stop
endmodule : rsfp_host

// >>> sim/tb_radio_spi_fifo_port.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_radio_spi_fifo_port import rsfp_pkg::*; ;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic serial_clk, serial_select_n, serial_in, serial_out, interrupt_out_n;
    logic power_down_in = 1'b0;
    logic transmit_antenna_select = 1'b0;
    logic receive_antenna_select = 1'b1;
    logic [2:0] gpio_out, gpio_oe;
    logic tx_pop, tx_data_valid;
    logic [7:0] tx_data;
    logic rx_push = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic [2:0] gpio_in = 3'h0;
    logic [15:0] hop_offset_10khz;
    logic [7:0] popped[$];
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    rsfp_port uut (.clk(clk), .nrst(nrst), .serial_clk(serial_clk), .serial_select_n(serial_select_n),
        .serial_in(serial_in), .serial_out(serial_out), .interrupt_out_n(interrupt_out_n),
        .power_down_in(power_down_in), .transmit_antenna_select(transmit_antenna_select),
        .receive_antenna_select(receive_antenna_select), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .tx_pop(tx_pop), .tx_data(tx_data), .tx_data_valid(tx_data_valid),
        .rx_push(rx_push), .rx_data(rx_data), .radio_events(8'h00), .hop_offset_10khz(hop_offset_10khz));

    rsfp_host host (.clk(clk), .serial_out(serial_out), .serial_clk(serial_clk),
        .serial_select_n(serial_select_n), .serial_in(serial_in));

    // ----------------------------------------
    // monitors and helpers
    // ----------------------------------------
    always @(posedge clk) begin
        if (tx_pop === 1'b1) popped.push_back(tx_data);
    end

    // ceiling well above the few thousand cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic results;
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic get(output logic [7:0] v);
        host.shift(8'h00, v);
    endtask : get

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.start(1'b1, a);
        host.shift(d, x);
        host.stop();
    endtask : wr

    task automatic push(input logic [7:0] d);
        wait_clk(1);
        rx_push = 1'b1;
        rx_data = d;
        wait_clk(1);
        rx_push = 1'b0;
    endtask : push

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // one incrementing burst walks the level registers, crossing an unmapped hole
    task automatic t_reset_values;
        logic [7:0] v;
        host.start(1'b0, ADDR_HOP_STEP);
        get(v); `CHK(v, RST_HOP_STEP)
        get(v); `CHK(v, 8'h00)
        get(v); `CHK(v, RST_TX_FULL_LEVEL)
        get(v); `CHK(v, RST_TX_EMPTY_LEVEL)
        get(v); `CHK(v, RST_RX_FULL_LEVEL)
        host.stop();
    endtask : t_reset_values

    task automatic t_hop;
        logic [7:0] v;
        wr(ADDR_HOP_CHANNEL, 8'h03);
        wr(ADDR_HOP_STEP, 8'h25);
        wait_clk(4);
        `CHK(hop_offset_10khz, 16'h006F)
        host.start(1'b0, ADDR_HOP_CHANNEL);
        get(v); `CHK(v, 8'h03)
        get(v); `CHK(v, 8'h25)
        host.stop();
    endtask : t_hop

    // bytes are loaded while receiving, then drained once transmit is selected
    task automatic t_tx_fifo;
        logic [7:0] x;
        transmit_antenna_select = 1'b0;
        receive_antenna_select = 1'b1;
        host.start(1'b1, ADDR_FIFO_PORT);
        host.shift(8'hA1, x);
        host.shift(8'hB2, x);
        host.shift(8'hC3, x);
        host.stop();
        `CHK(tx_data_valid, 1'b1)
        `CHK(tx_data, 8'hA1)
        transmit_antenna_select = 1'b1;
        receive_antenna_select = 1'b0;
        wait_clk(12);
        `CHK(popped.size(), 3)
        `CHK(popped[0], 8'hA1)
        `CHK(popped[1], 8'hB2)
        `CHK(popped[2], 8'hC3)
        `CHK(tx_data_valid, 1'b0)
        transmit_antenna_select = 1'b0;
        receive_antenna_select = 1'b1;
    endtask : t_tx_fifo

    task automatic t_rx_irq;
        logic [7:0] v;
        wr(ADDR_RX_FULL_LEVEL, 8'h02);
        wr(ADDR_IRQ_EN1, 8'h10);
        push(8'h5A);
        wait_clk(4);
        `CHK(interrupt_out_n, 1'b1)
        push(8'h6B);
        wait_clk(4);
        `CHK(interrupt_out_n, 1'b0)
        host.start(1'b0, ADDR_IRQ_STAT1);
        get(v); `CHK(v & 8'h10, 8'h10)
        host.stop();
        `CHK(interrupt_out_n, 1'b1)
        host.start(1'b0, ADDR_FIFO_PORT);
        get(v); `CHK(v, 8'h5A)
        get(v); `CHK(v, 8'h6B)
        get(v); `CHK(v, 8'h00)
        host.stop();
    endtask : t_rx_irq

    task automatic t_gpio;
        logic [7:0] v;
        wr(ADDR_GPIO0_CFG, 8'h07);
        wait_clk(3);
        `CHK(gpio_out[0], 1'b1)
        `CHK(gpio_oe[0], 1'b1)
        wr(ADDR_GPIO0_CFG, 8'h00);
        wait_clk(3);
        `CHK(gpio_out[0], 1'b0)
        gpio_in = 3'h5;
        wait_clk(4);
        host.start(1'b0, ADDR_IRQ_STAT2);
        get(v); `CHK(v, 8'h05)
        host.stop();
        gpio_in = 3'h0;
    endtask : t_gpio

    // step was written earlier, so a surviving value would show here
    task automatic t_power_down;
        logic [7:0] v;
        power_down_in = 1'b1;
        wait_clk(4);
        power_down_in = 1'b0;
        wait_clk(6);
        `CHK(hop_offset_10khz, 16'h0000)
        host.start(1'b0, ADDR_HOP_STEP);
        get(v); `CHK(v, RST_HOP_STEP)
        host.stop();
    endtask : t_power_down

    initial begin
        wait_clk(5);
        nrst = 1'b1;
        wait_clk(4);
        t_reset_values();
        t_hop();
        t_tx_fifo();
        t_rx_irq();
        t_gpio();
        t_power_down();
        results();
    end
endmodule : tb_radio_spi_fifo_port
